// ---- rtl/adc_ctrl_pkg.sv ----
// Behaviour
// - Each conversion samples the positive input, then the negative input half a conversion-clock period later.
// - The comparator decision is taken at the end of each conversion-clock period, after switching settles.
// - Config bit 3 low picks pair bits 2:1, and bit 0 chooses whether the odd or the even input is positive.
// - Bit 4 low with bit 3 high makes bits 2:0 the positive input against analog ground.
// - Bits 4 and 3 high with codes 000 to 110 make inputs 1 to 7 positive against input 8.
// - A read strobe held low over a whole selected write pulse keeps the old configuration.
// - A selected write strobe latches a new configuration from the bus and starts a conversion.
// - A selected read drives the stored result onto the bus and starts a conversion on the same configuration.
// - A write right after a read is accepted and restarts the conversion with the new configuration.
// - The result is 8-bit straight binary, all zeros for zero or negative input and all ones at full scale.
// - At conversion end the result enters the output latch and the done flag goes low; a selected read releases it.
// - A write falling edge releases the done flag and readies the converter; the rising edge with read high loads the config.
// - The config inputs share the low five bus lines and are taken only while read is high.
// - The conversion length follows the internal clock and never exceeds 40 microseconds.
package adc_ctrl_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_CLK_PERIOD_NS = 4000;
  localparam int CONV_TIME_MAX_US = 40;
  localparam int CONV_CLK_CYCLES = CONV_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CONV_TIME_MAX_CYCLES = CONV_TIME_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CLK_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(CONV_CLK_CYCLES / 2);
  // Pin vector positions after synchronising
  localparam int PIN_W = 11;
  localparam int PIN_CS = 10;
  localparam int PIN_WR = 9;
  localparam int PIN_RD = 8;
  // Config field positions
  localparam int CFG_W = 5;
  localparam int CFG_NOT_DIFF = 3;
  localparam int CFG_PSEUDO = 4;
  localparam logic [2:0] CFG_RESERVED = 3'h7;
  // Reset and start values
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] SAR_START = 8'h80;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
  // Selection that matches the reset config, pair 1/2 with input 1 positive
  localparam logic [7:0] POS_SEL_RESET = 8'h01;
  localparam logic [7:0] NEG_SEL_RESET = 8'h02;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_DECIDE = 3'b100
  } state_t;
endpackage : adc_ctrl_pkg

// ---- rtl/adc_mux_config_and_start_control.sv ----
`timescale 1ns/1ps
module adc_mux_config_and_start_control #(
  parameter int CONV_MAX_CYCLES = adc_ctrl_pkg::CONV_TIME_MAX_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus strobes from the host
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  // Shared data and config bus
  input wire logic [7:0] i_result_bus,
  output logic [7:0] o_result_bus,
  output logic o_result_bus_oe,
  // Completion flag
  output logic o_conversion_done_n,
  // Analog front end
  input wire logic i_comp_high,
  output logic [7:0] o_pos_sel,
  output logic [7:0] o_neg_sel,
  output logic o_neg_analog_ground_ref,
  output logic o_sample_pos,
  output logic o_sample_neg,
  output logic [7:0] o_dac_code
);
  logic [adc_ctrl_pkg::PIN_W-1:0] pin_s1, pin_s2, pin_s3, lvl, lvl_d;
  logic wr_fall, wr_rise, rd_fall, rd_held_low, conv_end, reserved;
  logic [adc_ctrl_pkg::CFG_W-1:0] cfg;
  adc_ctrl_pkg::state_t state;
  logic [adc_ctrl_pkg::CNT_W-1:0] cnt;
  logic [2:0] bit_idx;
  logic [7:0] result;
  logic [7:0] next_pos, next_neg;
  logic next_ground_ref;

  // Three-stage pin synchroniser
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1 <= {adc_ctrl_pkg::PIN_W{1'b1}};
      pin_s2 <= {adc_ctrl_pkg::PIN_W{1'b1}};
      pin_s3 <= {adc_ctrl_pkg::PIN_W{1'b1}};
    end else begin
      pin_s1 <= {i_cs_n, i_wr_n, i_rd_n, i_result_bus};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Accepted level changes only when stages two and three agree
  genvar g;
  generate
    for (g = 0; g < adc_ctrl_pkg::PIN_W; g++) begin : g_lvl
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          lvl[g] <= 1'b1;
          lvl_d[g] <= 1'b1;
        end else begin
          lvl_d[g] <= lvl[g];
          if (pin_s2[g] == pin_s3[g]) begin
            lvl[g] <= pin_s3[g];
          end
        end
      end
    end
  endgenerate

  // Chip-selected strobe edges
  assign wr_fall = lvl_d[adc_ctrl_pkg::PIN_WR] & ~lvl[adc_ctrl_pkg::PIN_WR]
                   & ~lvl[adc_ctrl_pkg::PIN_CS];
  assign wr_rise = ~lvl_d[adc_ctrl_pkg::PIN_WR] & lvl[adc_ctrl_pkg::PIN_WR]
                   & ~lvl[adc_ctrl_pkg::PIN_CS];
  assign rd_fall = lvl_d[adc_ctrl_pkg::PIN_RD] & ~lvl[adc_ctrl_pkg::PIN_RD]
                   & ~lvl[adc_ctrl_pkg::PIN_CS];
  assign conv_end = (state == adc_ctrl_pkg::ST_DECIDE) && (cnt == adc_ctrl_pkg::CNT_LAST)
                    && (bit_idx == 3'h0);
  assign reserved = cfg[adc_ctrl_pkg::CFG_PSEUDO] & cfg[adc_ctrl_pkg::CFG_NOT_DIFF]
                    & (cfg[2:0] == adc_ctrl_pkg::CFG_RESERVED);

  // Track read held low across the whole write pulse
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_held_low <= 1'b0;
    end else if (wr_fall) begin
      rd_held_low <= ~lvl[adc_ctrl_pkg::PIN_RD];
    end else if (lvl[adc_ctrl_pkg::PIN_RD]) begin
      rd_held_low <= 1'b0;
    end
  end

  // Mux decode of the bus config lines
  always_comb begin
    next_pos = 8'h00;
    next_neg = 8'h00;
    next_ground_ref = 1'b0;
    if (!lvl[adc_ctrl_pkg::CFG_NOT_DIFF]) begin
      next_pos[lvl[2:0]] = 1'b1;
      next_neg[{lvl[2:1], ~lvl[0]}] = 1'b1;
    end else if (!lvl[adc_ctrl_pkg::CFG_PSEUDO]) begin
      next_pos[lvl[2:0]] = 1'b1;
      next_ground_ref = 1'b1;
    end else begin
      if (lvl[2:0] != adc_ctrl_pkg::CFG_RESERVED) begin
        next_pos[lvl[2:0]] = 1'b1;
      end
      next_neg[7] = 1'b1;
    end
  end

  // Config latch on write rise with read high
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg <= adc_ctrl_pkg::CFG_RESET;
      o_pos_sel <= adc_ctrl_pkg::POS_SEL_RESET;
      o_neg_sel <= adc_ctrl_pkg::NEG_SEL_RESET;
      o_neg_analog_ground_ref <= 1'b0;
    end else if (wr_rise && !rd_held_low && lvl[adc_ctrl_pkg::PIN_RD]) begin
      cfg <= lvl[adc_ctrl_pkg::CFG_W-1:0];
      o_pos_sel <= next_pos;
      o_neg_sel <= next_neg;
      o_neg_analog_ground_ref <= next_ground_ref;
    end
  end

  // Conversion sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= adc_ctrl_pkg::ST_IDLE;
      cnt <= '0;
      bit_idx <= adc_ctrl_pkg::BIT_MSB;
      o_dac_code <= 8'h00;
      o_sample_pos <= 1'b0;
      o_sample_neg <= 1'b0;
    end else begin
      o_sample_pos <= 1'b0;
      o_sample_neg <= 1'b0;
      if (wr_rise || rd_fall) begin
        state <= adc_ctrl_pkg::ST_SAMPLE;
        cnt <= '0;
        bit_idx <= adc_ctrl_pkg::BIT_MSB;
        o_dac_code <= adc_ctrl_pkg::SAR_START;
        o_sample_pos <= 1'b1;
      end else if (wr_fall) begin
        state <= adc_ctrl_pkg::ST_IDLE;
        cnt <= '0;
      end else begin
        unique case (state)
          adc_ctrl_pkg::ST_IDLE: begin
            cnt <= '0;
          end
          adc_ctrl_pkg::ST_SAMPLE: begin
            cnt <= (cnt == adc_ctrl_pkg::CNT_LAST) ? '0 : cnt + 1'b1;
            o_sample_neg <= (cnt + 1'b1 == adc_ctrl_pkg::CNT_HALF);
            if (cnt == adc_ctrl_pkg::CNT_LAST) begin
              state <= adc_ctrl_pkg::ST_DECIDE;
            end
          end
          adc_ctrl_pkg::ST_DECIDE: begin
            cnt <= (cnt == adc_ctrl_pkg::CNT_LAST) ? '0 : cnt + 1'b1;
            if (cnt == adc_ctrl_pkg::CNT_LAST) begin
              o_dac_code[bit_idx] <= i_comp_high;
              if (bit_idx != 3'h0) begin
                o_dac_code[bit_idx - 3'h1] <= 1'b1;
                bit_idx <= bit_idx - 3'h1;
              end else begin
                state <= adc_ctrl_pkg::ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Output latch and completion flag, a landing result wins over a release
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      result <= adc_ctrl_pkg::RESULT_RESET;
      o_conversion_done_n <= 1'b1;
    end else begin
      if (conv_end) begin
        result <= reserved ? 8'h00 : {o_dac_code[7:1], i_comp_high};
        o_conversion_done_n <= 1'b0;
      end else if (rd_fall || wr_fall) begin
        o_conversion_done_n <= 1'b1;
      end
    end
  end

  // Bus drive while chip select and read are low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_result_bus <= adc_ctrl_pkg::RESULT_RESET;
      o_result_bus_oe <= 1'b0;
    end else begin
      o_result_bus <= result;
      o_result_bus_oe <= ~lvl[adc_ctrl_pkg::PIN_CS] & ~lvl[adc_ctrl_pkg::PIN_RD];
    end
  end

  // Helper counters for the checks below
  logic [adc_ctrl_pkg::CNT_W-1:0] since_pos;
  logic [15:0] conv_age;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      since_pos <= '0;
      conv_age <= '0;
    end else begin
      since_pos <= o_sample_pos ? 10'h001 : since_pos + 1'b1;
      // Restart the age on every start, a read may restart a running conversion
      conv_age <= (state == adc_ctrl_pkg::ST_IDLE || o_sample_pos) ? 16'h0000
                  : conv_age + 16'h0001;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_sample_done;
    (state == adc_ctrl_pkg::ST_SAMPLE) && (cnt == adc_ctrl_pkg::CNT_LAST) && !wr_rise
      && !rd_fall && !wr_fall;
  endsequence

  a_neg_after_half: assert property (o_sample_neg |-> since_pos == adc_ctrl_pkg::CNT_HALF)
    else $error("negative sample not half a period after positive");
  a_decide_at_end: assert property ((state == adc_ctrl_pkg::ST_DECIDE) && cnt
    != adc_ctrl_pkg::CNT_LAST && !wr_rise && !rd_fall |=> $stable(o_dac_code))
    else $error("decision taken before period end");
  a_sar_first_trial: assert property (s_sample_done |=> (state == adc_ctrl_pkg::ST_DECIDE)
    && (o_dac_code == adc_ctrl_pkg::SAR_START))
    else $error("successive approximation did not start at msb");
  a_diff_decode: assert property (!cfg[3] |-> o_pos_sel[cfg[2:0]] && o_neg_sel[{cfg[2:1],
    ~cfg[0]}] && !o_neg_analog_ground_ref)
    else $error("differential decode wrong");
  a_single_decode: assert property (cfg[4:3] == 2'b01 |-> o_neg_analog_ground_ref
    && o_pos_sel == (8'h01 << cfg[2:0]))
    else $error("single-ended decode wrong");
  a_pseudo_decode: assert property (cfg[4:3] == 2'b11 |-> o_neg_sel == 8'h80
    && (reserved ? o_pos_sel == 8'h00 : o_pos_sel[cfg[2:0]]))
    else $error("pseudo-differential decode wrong");
  a_keep_config: assert property (wr_rise && rd_held_low |=> $stable(cfg))
    else $error("config changed with read held low");
  a_write_loads: assert property (wr_rise && !rd_held_low && lvl[adc_ctrl_pkg::PIN_RD]
    |=> cfg == $past(lvl[4:0]) && state == adc_ctrl_pkg::ST_SAMPLE && cnt == '0)
    else $error("write did not load config and start");
  a_read_starts: assert property (rd_fall && !wr_rise |=> $stable(cfg)
    && state == adc_ctrl_pkg::ST_SAMPLE ##1 o_result_bus_oe)
    else $error("read did not start a conversion and drive the bus");
  a_done_lands: assert property (conv_end |=> !o_conversion_done_n
    && (result == 8'h00 || !$past(reserved)))
    else $error("done flag or result wrong at conversion end");
  a_wr_releases: assert property (wr_fall && !conv_end && !rd_fall |=> o_conversion_done_n
    && state == adc_ctrl_pkg::ST_IDLE)
    else $error("write falling edge did not release done");
  a_conv_bound: assert property (conv_age < 16'(CONV_MAX_CYCLES))
    else $error("conversion longer than allowed");
endmodule : adc_mux_config_and_start_control

// ---- verif/adc_host_model.sv ----
`timescale 1ns/1ps
// Bus master driving the strobes and the shared config lines
module adc_host_model (
  // Clock
  input wire logic i_clk,
  // Strobes and data toward the converter
  output logic o_cs_n,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic [7:0] o_data,
  output logic o_data_oe
);
  // Idle bus at time zero
  initial begin
    {o_cs_n, o_wr_n, o_rd_n, o_data_oe} = 4'hE;
    o_data = 8'h00;
  end

  // One bus state {cs_n, wr_n, rd_n, oe}, set after an edge, held 8 cycles
  task automatic step(input logic [3:0] s, input logic [7:0] d);
    @(posedge i_clk);
    {o_cs_n, o_wr_n, o_rd_n, o_data_oe} <= s;
    o_data <= d;
    repeat (7) @(posedge i_clk);
  endtask : step

  // Selected write: load a config, or keep it with read low throughout
  task automatic write_cfg(input logic [4:0] cfg, input logic keep);
    if (keep) begin
      step(4'h4, 8'h00);
      step(4'h0, 8'h00);
      step(4'h4, 8'h00);
    end else begin
      step(4'h3, {3'h0, cfg});
      step(4'h7, {3'h0, cfg});
    end
    step(4'hE, 8'h00);
  endtask : write_cfg

  // Selected read, left low so the result can be looked at
  task automatic read_start();
    step(4'h4, 8'h00);
  endtask : read_start

  // Release every strobe and the lines
  task automatic release_bus();
    step(4'hE, 8'h00);
  endtask : release_bus

  // Write strobe with chip select high
  task automatic stray(input logic [4:0] cfg);
    step(4'hB, {3'h0, cfg});
    step(4'hF, {3'h0, cfg});
    step(4'hE, 8'h00);
  endtask : stray
endmodule : adc_host_model

// ---- verif/adc_mux_config_and_start_control_tb.sv ----
`timescale 1ns/1ps
module adc_mux_config_and_start_control_tb;
  localparam int LIMIT = 80000;
  localparam int CONV_MAX = adc_ctrl_pkg::CONV_TIME_MAX_CYCLES;
  logic i_clk, i_rst, i_comp_high, cs_n, wr_n, rd_n, h_oe, oe, done_n, gnd_ref, s_pos, s_neg;
  logic [7:0] h_data, ain, res, pos, neg, dac, v;
  wire logic [7:0] bus;
  int cyc, fails, checked, n_pos, t_pos, t_neg, seed, np;

  // Bus level from whoever drives it, a changing pattern when released
  assign bus = oe ? res : (h_oe ? h_data : (cyc[7:0] ^ 8'hA5));

  adc_host_model u_host (.i_clk(i_clk), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n),
    .o_data(h_data), .o_data_oe(h_oe));

  adc_mux_config_and_start_control u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n),
    .i_wr_n(wr_n), .i_rd_n(rd_n), .i_result_bus(bus), .o_result_bus(res),
    .o_result_bus_oe(oe), .o_conversion_done_n(done_n), .i_comp_high(i_comp_high),
    .o_pos_sel(pos), .o_neg_sel(neg), .o_neg_analog_ground_ref(gnd_ref), .o_sample_pos(s_pos),
    .o_sample_neg(s_neg), .o_dac_code(dac));

  // Clock
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // Comparator: input level at or above the trial code
  always @(posedge i_clk) i_comp_high <= (dac <= ain);

  // Cycle count, sample pulse times, hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (s_pos === 1'b1) begin
      n_pos <= n_pos + 1;
      t_pos <= cyc;
    end
    if (s_neg === 1'b1) t_neg <= cyc;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      results();
    end
  end

  // Expected {ground ref, negative one-hot, positive one-hot}
  function automatic logic [16:0] exp_mux(input logic [4:0] c);
    logic [7:0] p;
    logic [7:0] n;
    p = 8'h01 << c[2:0];
    n = 8'h00;
    if (!c[3]) n = 8'h01 << {c[2:1], ~c[0]};
    else if (c[4]) n = 8'h80;
    if (c[4:3] == 2'h3 && c[2:0] == 3'h7) p = 8'h00;
    return {c[4:3] == 2'h1, n, p};
  endfunction : exp_mux

  // Compare one value, count it, report a mismatch
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Compare the decoded input selection
  task automatic mux_chk(input logic [4:0] c);
    chk("mux", exp_mux(c), {gnd_ref, neg, pos});
  endtask : mux_chk

  // Load a config, convert one level, read it back
  task automatic convert(input logic [4:0] c, input logic [7:0] lvl, input logic [7:0] exp);
    int i;
    ain <= lvl;
    u_host.write_cfg(c, 1'b0);
    mux_chk(c);
    chk("done_release", 17'h1, {16'h0, done_n});
    for (i = 0; i < CONV_MAX && done_n !== 1'b0; i++) @(posedge i_clk);
    chk("neg_gap", 17'(adc_ctrl_pkg::CNT_HALF), 17'(t_neg - t_pos));
    chk("in_time", 17'h1, {16'h0, (cyc - t_pos) <= CONV_MAX});
    u_host.read_start();
    chk("result", {8'h0, 1'b1, exp}, {8'h0, oe, res});
    chk("read_release", 17'h1, {16'h0, done_n});
    u_host.release_bus();
  endtask : convert

  // Counts and verdict
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    seed = 32'h314a;
    {i_rst, i_comp_high, ain, cyc, fails, checked, n_pos, t_pos, t_neg} = '0;
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 32; k++) begin
      u_host.write_cfg(5'(k), 1'b0);
      mux_chk(5'(k));
      chk("starts", 17'(k + 1), 17'(n_pos));
    end
    u_host.write_cfg(5'h08, 1'b1);
    mux_chk(5'h1F);
    np = n_pos;
    u_host.stray(5'h08);
    chk("stray", 17'(np), 17'(n_pos));
    v = 8'($random(seed));
    convert(5'h08 | 5'($random(seed) & 7), v, v);
    convert(5'h1C, 8'hFF, 8'hFF);
    // Let the read-started conversion finish so the next write must release done
    for (int i = 0; i < CONV_MAX && done_n !== 1'b0; i++) @(posedge i_clk);
    chk("done_low", 17'h0, {16'h0, done_n});
    convert(5'h1F, 8'h5A, 8'h00);
    convert(5'h03, 8'h00, 8'h00);
    np = n_pos;
    u_host.read_start();
    u_host.release_bus();
    chk("read_start", 17'(np + 1), 17'(n_pos));
    mux_chk(5'h03);
    v = 8'($random(seed));
    convert(5'h0E, v, v);
    results();
  end
endmodule : adc_mux_config_and_start_control_tb
